// ===== hw/tis_regs.svh
// Constants for the thermocouple input sequencer: fields, codes, limits, timing
`ifndef TIS_REGS_SVH
`define TIS_REGS_SVH

// Channel count and image word width
`define TIS_NUM_CH 8
`define TIS_WORD_W 16

// Configuration word fields (one word per channel)
`define TIS_CFG_EN 0
`define TIS_CFG_TYPE_LSB 1
`define TIS_CFG_TYPE_MSB 4
`define TIS_CFG_STAT_SEL 5
`define TIS_CFG_OC_EN 6

// Status word fields
`define TIS_ST_TYPE_LSB 0
`define TIS_ST_TYPE_MSB 3
`define TIS_ST_OPEN 12
`define TIS_ST_UNDER 13
`define TIS_ST_OVER 14
`define TIS_ST_ERR 15

// Input type codes
`define TIS_TYPE_J 4'h0
`define TIS_TYPE_K 4'h1
`define TIS_TYPE_T 4'h2
`define TIS_TYPE_B 4'h3
`define TIS_TYPE_E 4'h4
`define TIS_TYPE_R 4'h5
`define TIS_TYPE_S 4'h6
`define TIS_TYPE_N 4'h7
`define TIS_TYPE_MV50 4'h8
`define TIS_TYPE_MV100 4'h9

// Thermocouple limits in whole degrees C
`define TIS_J_LO -210
`define TIS_J_HI 760
`define TIS_K_LO -270
`define TIS_K_HI 1370
`define TIS_T_LO -270
`define TIS_T_HI 400
`define TIS_B_LO 300
`define TIS_B_HI 1820
`define TIS_E_LO -270
`define TIS_E_HI 1000
`define TIS_R_LO 0
`define TIS_R_HI 1768
`define TIS_S_LO 0
`define TIS_S_HI 1768
`define TIS_N_LO 0
`define TIS_N_HI 1300

// Millivolt limits in converter counts (symmetric)
`define TIS_MV50_LIM 16000
`define TIS_MV100_LIM 32000

// Fixed point shift of the linear gain
`define TIS_GAIN_SHIFT 12

// Timing: clock rate and indicator flash half period
`define TIS_CLK_MHZ 100
`define TIS_FLASH_MS 250

`endif

// ===== hw/tis_pkg.sv
// Types shared by the thermocouple input sequencer
package tis_pkg;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        TIS_ST_SELFTEST = 5'h01,
        TIS_ST_FAULT = 5'h02,
        TIS_ST_IDLE = 5'h04,
        TIS_ST_PICK = 5'h08,
        TIS_ST_CONV = 5'h10
    } tis_state_t;

    // One image table word
    typedef logic [15:0] tis_word_t;

endpackage

// ===== hw/tis_conv_if.sv
// Carrier between the sequencer and its compensation and linearizer
`timescale 1ns/1ps
interface tis_conv_if;
    logic signed [15:0] raw; // Converter counts
    logic [3:0] ctype; // Input type code
    logic signed [15:0] cj_temp; // Cold junction temperature, deg C
    logic signed [15:0] result; // Compensated, clamped reading
    logic over; // Reading above range
    logic under; // Reading below range
    logic bad; // Unknown input type

    modport seq (output raw, ctype, cj_temp,
                 input result, over, under, bad);
    modport lin (input raw, ctype, cj_temp,
                 output result, over, under, bad);
endinterface

// ===== hw/tis_linearize.sv
// Cold junction compensation, linearization and range check of one reading
`timescale 1ns/1ps
`include "tis_regs.svh"
module tis_linearize
    import tis_pkg::*;
(
    tis_conv_if.lin conv // Reading in, result and range flags out
);

    // Per type gain, fixed point; values are a plain first-order fit
    localparam logic signed [15:0] GAIN [0:7] = '{
        16'sh0100, 16'sh0140, 16'sh0130, 16'sh0300,
        16'sh00E0, 16'sh0400, 16'sh0420, 16'sh0160
    };

    logic signed [31:0] prod; // Counts times gain
    logic signed [31:0] temp; // Unclamped reading
    logic signed [31:0] lo; // Lower limit of selected range
    logic signed [31:0] hi; // Upper limit of selected range
    logic is_mv; // Millivolt mode

    // Compensate, linearize and clamp
    always_comb
    begin
        prod = 32'sh0;
        lo = 32'sh0;
        hi = 32'sh0;
        is_mv = 1'b0;
        conv.bad = 1'b0;
        case (conv.ctype)
            `TIS_TYPE_J: begin lo = `TIS_J_LO; hi = `TIS_J_HI; end
            `TIS_TYPE_K: begin lo = `TIS_K_LO; hi = `TIS_K_HI; end
            `TIS_TYPE_T: begin lo = `TIS_T_LO; hi = `TIS_T_HI; end
            `TIS_TYPE_B: begin lo = `TIS_B_LO; hi = `TIS_B_HI; end
            `TIS_TYPE_E: begin lo = `TIS_E_LO; hi = `TIS_E_HI; end
            `TIS_TYPE_R: begin lo = `TIS_R_LO; hi = `TIS_R_HI; end
            `TIS_TYPE_S: begin lo = `TIS_S_LO; hi = `TIS_S_HI; end
            `TIS_TYPE_N: begin lo = `TIS_N_LO; hi = `TIS_N_HI; end
            `TIS_TYPE_MV50:
            begin
                is_mv = 1'b1;
                lo = -`TIS_MV50_LIM;
                hi = `TIS_MV50_LIM;
            end
            `TIS_TYPE_MV100:
            begin
                is_mv = 1'b1;
                lo = -`TIS_MV100_LIM;
                hi = `TIS_MV100_LIM;
            end
            default: conv.bad = 1'b1; // Unknown type code
        endcase
        if (!conv.ctype[3])
        begin
            prod = 32'(conv.raw) * 32'(GAIN[conv.ctype[2:0]]);
        end
        if (is_mv)
        begin
            temp = 32'(conv.raw);
        end
        else
        begin
            temp = (prod >>> `TIS_GAIN_SHIFT) + 32'(conv.cj_temp);
        end
        conv.over = !conv.bad && (temp > hi);
        conv.under = !conv.bad && (temp < lo);
        // Clamp into the selected range
        if (conv.over)
        begin
            conv.result = hi[15:0];
        end
        else if (conv.under)
        begin
            conv.result = lo[15:0];
        end
        else
        begin
            conv.result = temp[15:0];
        end
    end

endmodule

// ===== hw/tis_sequencer.sv
// Control logic of the eight-channel thermocouple input sequencer
// Overview of operation
// - Self-check at power-up, module indicator dark
// - Self-check passes, module indicator on
// - Idle, channel indicators dark, until configuration
// - Configured enabled channel lights its indicator
// - Enabled channels convert continuously within range
// - Every reading of a known type checked for over/under range
// - Open-circuit tested only when enabled
// - Fault sets status bit, indicator flashes
// - Eight input words, eight output words
// - Input word is data or status, selectable
// - Multiplex eight inputs into one converter
// - Sample cold junction sensors, compensate readings
// - Thermocouple readings compensated and linearized
// - Millivolt mode reports raw counts
// - Per channel type J..N or two mV
`timescale 1ns/1ps
`include "tis_regs.svh"
module tis_sequencer
    import tis_pkg::*;
#(
    parameter int NUM_CH = `TIS_NUM_CH, // Channel count
    parameter int unsigned FLASH_CYCLES =
        `TIS_FLASH_MS * 1000 * `TIS_CLK_MHZ // Flash half period
)
(
    input wire logic clk_i, // 100 MHz clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic selftest_done_i, // Self-check finished
    input wire logic selftest_fault_i, // Self-check found a fault
    input wire logic cfg_valid_i, // Configuration words valid
    input wire logic [7:0][15:0] cfg_word_i, // Output image, config
    input wire logic adc_done_i, // Conversion finished
    input wire logic signed [15:0] adc_data_i, // Converter counts
    input wire logic open_circuit_i, // Open input sensed
    input wire logic signed [15:0] cj0_temp_i, // Cold junction 0, deg C
    input wire logic signed [15:0] cj1_temp_i, // Cold junction 1, deg C
    output logic module_led_o, // Module status indicator
    output logic [7:0] chan_led_o, // Channel status indicators
    output logic [2:0] mux_sel_o, // Input multiplexer select
    output logic adc_start_o, // Conversion start pulse
    output logic [7:0][15:0] in_word_o // Input image words
);

    tis_state_t state; // Sequencer state
    logic [2:0] cur_ch; // Channel being converted
    logic [2:0] next_ch; // Next enabled channel
    logic any_en; // Some channel enabled
    logic [7:0] en; // Channel enable bits
    tis_word_t data_q [0:7]; // Last reading per channel
    tis_word_t stat_q [0:7]; // Last status per channel
    logic signed [16:0] cj_sum; // Sum of both junction sensors
    logic signed [15:0] cj_avg; // Averaged junction temperature
    logic [31:0] flash_cnt; // Flash half period counter
    logic flash_phase; // Flash on/off phase
    logic running; // Configured and converting
    logic oc_now; // Open circuit, gated by enable
    logic capture; // Reading completes this cycle

    tis_conv_if conv (); // Link to the linearizer

    // Compensation and linearization of the current reading
    tis_linearize u_lin (
        .conv(conv)
    );

    // Decode per channel enables from the configuration words
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            en[c] = cfg_word_i[c][`TIS_CFG_EN];
        end
    end

    // Round-robin search for the next enabled channel
    always_comb
    begin
        logic [3:0] probe;
        probe = 4'h0;
        next_ch = cur_ch;
        any_en = 1'b0;
        for (int k = 1; k <= NUM_CH; k++)
        begin
            probe = {1'b0, cur_ch} + 4'(k);
            if (!any_en && en[probe[2:0]])
            begin
                next_ch = probe[2:0];
                any_en = 1'b1;
            end
        end
    end

    // Feed the linearizer with the current reading
    assign conv.raw = adc_data_i;
    assign conv.ctype =
        cfg_word_i[cur_ch][`TIS_CFG_TYPE_MSB:`TIS_CFG_TYPE_LSB];
    assign conv.cj_temp = cj_avg;
    assign running = (state == TIS_ST_PICK) || (state == TIS_ST_CONV);
    assign capture = (state == TIS_ST_CONV) && adc_done_i;
    assign oc_now = open_circuit_i &&
        cfg_word_i[cur_ch][`TIS_CFG_OC_EN];
    assign cj_sum = {cj0_temp_i[15], cj0_temp_i} +
        {cj1_temp_i[15], cj1_temp_i};

    // Sequencer: self-check, wait for configuration, convert
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= TIS_ST_SELFTEST;
            cur_ch <= 3'h7;
            mux_sel_o <= 3'h0;
            adc_start_o <= 1'b0;
        end
        else
        begin
            adc_start_o <= 1'b0;
            case (state)
                TIS_ST_SELFTEST:
                begin
                    // Wait for the built-in check to finish
                    if (selftest_done_i)
                    begin
                        state <= selftest_fault_i ? TIS_ST_FAULT
                                                  : TIS_ST_IDLE;
                    end
                end
                TIS_ST_FAULT:
                begin
                    state <= TIS_ST_FAULT; // Failed check, stay dark
                end
                TIS_ST_IDLE:
                begin
                    // Hold off until configuration arrives
                    if (cfg_valid_i)
                    begin
                        state <= TIS_ST_PICK;
                    end
                end
                TIS_ST_PICK:
                begin
                    // Select the next enabled channel and start
                    if (any_en)
                    begin
                        cur_ch <= next_ch;
                        mux_sel_o <= next_ch;
                        adc_start_o <= 1'b1;
                        state <= TIS_ST_CONV;
                    end
                end
                TIS_ST_CONV:
                begin
                    // Hold the mux until the reading is in
                    if (adc_done_i)
                    begin
                        state <= TIS_ST_PICK;
                    end
                end
                default:
                begin
                    state <= TIS_ST_SELFTEST; // Recover from bad code
                end
            endcase
        end
    end

    // Continuous cold junction sampling, average of both sensors
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cj_avg <= 16'sh0;
        end
        else
        begin
            cj_avg <= cj_sum[16:1];
        end
    end

    // Store reading and status of the converted channel only
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                data_q[c] <= 16'h0000;
                stat_q[c] <= 16'h0000;
            end
        end
        else if (capture)
        begin
            data_q[cur_ch] <= conv.result;
            stat_q[cur_ch] <= 16'h0000;
            stat_q[cur_ch][`TIS_ST_TYPE_MSB:`TIS_ST_TYPE_LSB] <= conv.ctype;
            stat_q[cur_ch][`TIS_ST_OPEN] <= oc_now;
            stat_q[cur_ch][`TIS_ST_UNDER] <= conv.under;
            stat_q[cur_ch][`TIS_ST_OVER] <= conv.over;
            stat_q[cur_ch][`TIS_ST_ERR] <= oc_now || conv.under ||
                conv.over || conv.bad;
        end
    end

    // Module indicator: dark in self-check, on once it passes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            module_led_o <= 1'b0;
        end
        else if ((state == TIS_ST_SELFTEST) && selftest_done_i &&
                 !selftest_fault_i)
        begin
            module_led_o <= 1'b1;
        end
    end

    // Flash timebase for faulted channel indicators
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flash_cnt <= 32'h0;
            flash_phase <= 1'b0;
        end
        else if (flash_cnt == FLASH_CYCLES - 1)
        begin
            flash_cnt <= 32'h0;
            flash_phase <= !flash_phase;
        end
        else
        begin
            flash_cnt <= flash_cnt + 32'h1;
        end
    end

    // Channel indicators: off, steady on, or flashing on fault
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            chan_led_o <= 8'h00;
        end
        else
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (!running || !en[c])
                begin
                    chan_led_o[c] <= 1'b0;
                end
                else if (stat_q[c][`TIS_ST_ERR])
                begin
                    chan_led_o[c] <= flash_phase;
                end
                else
                begin
                    chan_led_o[c] <= 1'b1;
                end
            end
        end
    end

    // Input image: reading or status per channel select bit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            in_word_o <= '0;
        end
        else
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                in_word_o[c] <= cfg_word_i[c][`TIS_CFG_STAT_SEL]
                    ? stat_q[c] : data_q[c];
            end
        end
    end

    // Start pulse in the conversion state, then the mux held steady
    sequence s_start;
        adc_start_o && (state == TIS_ST_CONV);
    endsequence

    sequence s_hold;
        $stable(mux_sel_o) throughout (state == TIS_ST_CONV)[*1];
    endsequence

    AST_DARK_SELFTEST: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == TIS_ST_SELFTEST) |-> !module_led_o)
        else $error("module indicator lit during self-check");

    AST_LED_ON_PASS: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ((state == TIS_ST_SELFTEST) && selftest_done_i &&
         !selftest_fault_i) |=> module_led_o && (state == TIS_ST_IDLE))
        else $error("module indicator not on after passing check");

    AST_IDLE_DARK: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == TIS_ST_IDLE) |-> (chan_led_o == 8'h00) && !adc_start_o)
        else $error("channel activity before configuration");

    AST_CHAN_ON: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (running && en[0] && !stat_q[0][`TIS_ST_ERR]) |=> chan_led_o[0])
        else $error("enabled healthy channel indicator dark");

    AST_START_PICK: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ((state == TIS_ST_PICK) && any_en) |=> s_start ##0
        en[mux_sel_o] && (mux_sel_o == cur_ch))
        else $error("enabled channel not started");

    AST_MUX_HOLD: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_start ##1 s_hold |-> (mux_sel_o == cur_ch))
        else $error("mux moved during conversion");

    AST_OVER_FLAG: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (capture && conv.over) |=> stat_q[cur_ch][`TIS_ST_OVER] &&
        stat_q[cur_ch][`TIS_ST_ERR])
        else $error("over-range not flagged");

    AST_OC_GATE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (capture && !cfg_word_i[cur_ch][`TIS_CFG_OC_EN]) |=>
        !stat_q[cur_ch][`TIS_ST_OPEN])
        else $error("open circuit flagged while disabled");

    // Sampled reset keeps the release edge out, the flop still held zero
    AST_CJ_TRACK: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i && $stable(cj0_temp_i) && $stable(cj1_temp_i) |=>
        (cj_avg == $past(cj_sum[16:1])))
        else $error("cold junction average lags");

    AST_FAULT_FLASH: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (running && en[0] && stat_q[0][`TIS_ST_ERR] &&
         $stable(stat_q[0])) |=> (chan_led_o[0] == $past(flash_phase)))
        else $error("faulted channel indicator not flashing");

endmodule

// ===== dv/tis_adc_model.sv
// Converter model on the far side of the sequencer
`timescale 1ns/1ps
module tis_adc_model
    import tis_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic start_i, // Conversion start pulse
    input wire logic [2:0] sel_i, // Multiplexer select
    input wire logic [7:0][15:0] tab_i, // Counts per channel
    input wire logic [7:0] open_i, // Open input per channel
    output logic done_o, // Conversion finished
    output logic signed [15:0] data_o, // Converter counts
    output logic open_o, // Open input sensed
    output int n_done_o // Conversions finished so far
);
    logic busy; // Conversion running
    logic slow; // Alternates prompt and slow answers
    int wait_cnt; // Cycles left before done
    logic [15:0] held; // Counts latched at start
    logic held_open; // Open flag latched at start

    // One conversion at a time, alternating latency
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {busy, slow, done_o, open_o, held_open} <= 5'h00;
            {wait_cnt, n_done_o} <= '0;
            {held, data_o} <= {16'h0000, 16'h5A5A};
        end
        else
        begin
            done_o <= 1'b0;
            // Lines carry no value between results
            data_o <= ~data_o;
            open_o <= ~open_o;
            if (start_i && !busy)
            begin
                busy <= 1'b1;
                held <= tab_i[sel_i];
                held_open <= open_i[sel_i];
                wait_cnt <= slow ? 5 : 0;
                slow <= ~slow;
            end
            else if (busy && wait_cnt == 0)
            begin
                done_o <= 1'b1;
                data_o <= held;
                open_o <= held_open;
                busy <= 1'b0;
                n_done_o <= n_done_o + 1;
            end
            else if (busy)
                wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// ===== dv/tis_sequencer_bench.sv
// Self-checking bench of the thermocouple input sequencer
`timescale 1ns/1ps
`include "tis_regs.svh"
module tis_sequencer_bench
    import tis_pkg::*;
;
    localparam int CJ0 = 20; // Junction 0, deg C
    localparam int CJ1 = 30; // Junction 1, deg C
    localparam int CJ_AVG = (CJ0 + CJ1) / 2; // Compensation term

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic st_done = 1'b0; // Self-check finished
    logic st_fault = 1'b0; // Self-check found a fault
    logic cfg_valid = 1'b0; // Configuration valid
    logic [7:0][15:0] cfg = '0; // Configuration words
    logic [7:0][15:0] adc_tab = '0; // Counts per channel
    logic [7:0] open_tab = 8'h00; // Open inputs
    logic adc_done, open_c, module_led, adc_start;
    logic signed [15:0] adc_data;
    logic [7:0] chan_led;
    logic [2:0] mux_sel;
    logic [7:0][15:0] in_word;
    logic [7:0] visited = 8'h00; // Channels ever started
    int n_done, fails = 0, n_compared = 0, cycles = 0;

    // Clock 100 MHz
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    tis_sequencer #(.FLASH_CYCLES(4)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .selftest_done_i(st_done),
        .selftest_fault_i(st_fault), .cfg_valid_i(cfg_valid),
        .cfg_word_i(cfg), .adc_done_i(adc_done), .adc_data_i(adc_data),
        .open_circuit_i(open_c), .cj0_temp_i(16'(CJ0)),
        .cj1_temp_i(16'(CJ1)), .module_led_o(module_led),
        .chan_led_o(chan_led), .mux_sel_o(mux_sel),
        .adc_start_o(adc_start), .in_word_o(in_word));

    tis_adc_model ADC (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(adc_start),
        .sel_i(mux_sel), .tab_i(adc_tab), .open_i(open_tab),
        .done_o(adc_done), .data_o(adc_data), .open_o(open_c),
        .n_done_o(n_done));

    // Started channels and hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (adc_start)
            visited[mux_sel] <= 1'b1;
        if (cycles == 20000)
        begin
            fails++;
            finish_test;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Lower range limit of a thermocouple type
    function automatic int tc_lo(input int t);
        case (t)
            0: return `TIS_J_LO;
            1: return `TIS_K_LO;
            2: return `TIS_T_LO;
            3: return `TIS_B_LO;
            4: return `TIS_E_LO;
            5: return `TIS_R_LO;
            6: return `TIS_S_LO;
            default: return `TIS_N_LO;
        endcase
    endfunction

    // Wait for n finished conversions, then let results land
    task automatic wait_conv(input int n);
        int target = n_done + n;
        int k = 0;
        while (n_done < target && k < 500)
        begin
            @(posedge clk_i);
            k++;
        end
        chk("conversions keep running", 16'h0001, 16'(k < 500));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Indicator must show both levels over three half periods
    task automatic chk_flash(input int ch);
        logic seen0 = 1'b0;
        logic seen1 = 1'b0;
        repeat (12)
        begin
            @(negedge clk_i);
            seen0 |= (chan_led[ch] === 1'b0);
            seen1 |= (chan_led[ch] === 1'b1);
        end
        chk("led flashes", 16'h0001, {15'h0, seen0 & seen1});
    endtask

    // Self-check, then idle despite enables while not valid
    task automatic t_power_up;
        cfg[0] <= 16'h0011; // Enabled, millivolt 50, data
        cfg[2] <= 16'h0001; // Enabled, type J, data
        adc_tab[0] <= 16'h04D2;
        adc_tab[2] <= 16'h0640;
        repeat (3) @(negedge clk_i);
        chk("module led in self-check", 16'h0000, 16'(module_led));
        @(posedge clk_i);
        st_done <= 1'b1;
        @(posedge clk_i);
        st_done <= 1'b0;
        repeat (10) @(negedge clk_i);
        chk("module led after check", 16'h0001, 16'(module_led));
        chk("chan leds idle", 16'h0000, 16'(chan_led));
        chk("starts while idle", 16'h0000, 16'(visited));
    endtask

    // Round robin over channels 0 and 2, millivolt and type J
    task automatic t_convert;
        @(posedge clk_i);
        cfg_valid <= 1'b1;
        wait_conv(4);
        chk("mV counts ch0", 16'h04D2, in_word[0]);
        chk("J reading ch2", 16'(100 + CJ_AVG), in_word[2]);
        chk("disabled word ch1", 16'h0000, in_word[1]);
        chk("chan leds on", 16'h0005, 16'(chan_led));
        chk("channels visited", 16'h0005, 16'(visited));
    endtask

    // Every type code and one unknown code at zero counts, status shown
    task automatic t_types;
        logic [15:0] exp;
        for (int t = 0; t < 11; t++)
        begin
            @(posedge clk_i);
            cfg[0] <= {9'h0, 1'b0, 1'b1, 4'(t), 1'b1};
            adc_tab[0] <= 16'h0000;
            wait_conv(4);
            exp = {12'h0, 4'(t)};
            if (t < 8 && CJ_AVG < tc_lo(t))
                exp = exp | 16'hA000;
            if (t > 9)
                exp = exp | 16'h8000; // Unknown code: error bit only
            chk("status per type", exp, in_word[0]);
            if (exp[15])
                chk_flash(0);
            else
                chk("steady led", 16'h0001, 16'(chan_led[0]));
        end
    endtask

    // Millivolt limits, clamping and boundary
    task automatic t_range;
        logic [4:0] cw [5] = '{5'h18, 5'h18, 5'h18, 5'h09, 5'h09};
        logic [15:0] raw [5] = '{16'h4E20, 16'hB1E0, 16'h3E80, 16'h7D01,
                                 16'h82FF};
        logic [15:0] exp [5] = '{16'hC008, 16'hA008, 16'h0008, 16'h7D00,
                                 16'h8300};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_i);
            cfg[0] <= {10'h0, cw[i][4], cw[i][3:0], 1'b1};
            adc_tab[0] <= raw[i];
            wait_conv(4);
            chk("mV range word", exp[i], in_word[0]);
        end
    endtask

    // Open input flagged only with detection on
    task automatic t_open;
        logic [15:0] exp [3] = '{16'h0008, 16'h9008, 16'h0008};
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            cfg[0] <= {9'h0, 1'(i != 0), 1'b1, 4'h8, 1'b1};
            adc_tab[0] <= 16'h0000;
            open_tab[0] <= 1'(i < 2);
            wait_conv(4);
            chk("open status", exp[i], in_word[0]);
        end
    endtask

    // Mid-run reset, then a failed self-check keeps everything dark
    task automatic t_fault;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        st_fault <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        st_done <= 1'b1;
        @(posedge clk_i);
        st_done <= 1'b0;
        repeat (20) @(negedge clk_i);
        chk("module led after fault", 16'h0000, 16'(module_led));
        chk("chan leds after fault", 16'h0000, 16'(chan_led));
        chk("starts after fault", 16'h0000, 16'(n_done));
    endtask

    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Reset for four cycles, then the scenarios
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_power_up;
        t_convert;
        t_types;
        t_range;
        t_open;
        t_fault;
        finish_test;
    end
endmodule
